/* dco_correlator_out.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dco_params.svh"

// Notes on behaviour
// - three separate 32-bit output data paths
// - each line carries one value per clock edge
// - forward 128 MHz clock, data on both edges
// - frame goes out as four consecutive words
// - frame opening word follows each reference rise
// - forwarded clock comes from on-chip PLL
// - emit one-second and ten-second pulses
// - armed counters start on metaframe index frame
// - pulse counters advance on received frames
// - flag invalid when frame sync is missing
// - flag invalid when channel frame counters differ
// - flag invalid on 8-bit extreme codes
module dco_correlator_out
#(
  parameter int unsigned FRAMES_PER_SEC = `DCO_FRAME_RATE_HZ
)
(
  // receive side clock and reset
  input  wire logic        I_CLK,
  input  wire logic        I_RESET_N,
  // word clock from the PLL locked to the reference
  input  wire logic        I_LINK_CLK,
  // reference from the correlator
  input  wire logic        I_REF_CLK,
  // received words, channel n at bits n*32
  input  wire logic [95:0] I_CH_DATA,
  input  wire logic [2:0]  I_CH_VALID,
  input  wire logic [2:0]  I_CH_SOF,
  input  wire logic [47:0] I_CH_FCNT,
  input  wire logic [2:0]  I_CH_MFI,
  input  wire logic [2:0]  I_CH_SYNC,
  // mode and control
  input  wire logic        I_SAMPLE_3BIT,
  input  wire logic        I_ARM,
  // data paths to the correlator
  output var  logic [31:0] O_PATH0_DATA,
  output var  logic [31:0] O_PATH1_DATA,
  output var  logic [31:0] O_PATH2_DATA,
  output var  logic        O_DDR_CLK,
  output var  logic        O_DATA_INVALID,
  // timing pulses and status
  output var  logic        O_PULSE_1S,
  output var  logic        O_PULSE_10S,
  output var  logic        O_COUNT_RUN
);

  // ---------------- receive domain ----------------

  dco_frame_if fif [3] ();

  // one assembler per fiber channel
  genvar g;
  for (g = 0; g < 3; g++)
  begin : g_ch
    dco_frame_asm u_asm
    (
      .clk     (I_CLK),
      .rst_n   (I_RESET_N),
      .i_word  (I_CH_DATA[g*32 +: 32]),
      .i_valid (I_CH_VALID[g]),
      .i_sof   (I_CH_SOF[g]),
      .i_fcnt  (I_CH_FCNT[g*16 +: 16]),
      .i_mfi   (I_CH_MFI[g]),
      .i_mode3 (I_SAMPLE_3BIT),
      .fr      (fif[g])
    );
  end

  logic         req_ff;        // toggles per handed frame
  logic         ack_s1_ff;     // ack sync, first stage
  logic         ack_s2_ff;     // ack sync, second stage
  logic         ack_ff;        // returned toggle, link domain
  logic [383:0] hold_ff;       // frames for the link side
  logic         hold_inv_ff;   // invalid tag with them

  // all three channels must have a frame; stalls them otherwise
  wire all_valid = fif[0].valid & fif[1].valid & fif[2].valid;
  wire idle      = (req_ff == ack_s2_ff);
  wire capture   = all_valid & idle;

  assign fif[0].ready = capture;
  assign fif[1].ready = capture;
  assign fif[2].ready = capture;

  // invalid conditions, judged per frame so the tag rides with it
  wire sync_bad = ~(&I_CH_SYNC);
  wire fcnt_bad = (fif[0].fcnt != fif[1].fcnt) ||
                  (fif[1].fcnt != fif[2].fcnt);
  wire ovr_bad  = fif[0].ovr | fif[1].ovr | fif[2].ovr;
  wire inv_now  = sync_bad | fcnt_bad | ovr_bad;

  // ack from the link side crosses back in two stages
  always_ff @(posedge I_CLK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      ack_s1_ff <= 1'b0;
      ack_s2_ff <= 1'b0;
    end
    else
    begin
      ack_s1_ff <= ack_ff;
      ack_s2_ff <= ack_s1_ff;
    end
  end

  // hold stays still while the request is open
  always_ff @(posedge I_CLK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      req_ff      <= 1'b0;
      hold_ff     <= '0;
      hold_inv_ff <= 1'b1;
    end
    else if (capture)
    begin
      req_ff      <= ~req_ff;
      hold_ff     <= {fif[2].frame, fif[1].frame, fif[0].frame};
      hold_inv_ff <= inv_now;
    end
  end

  // ---------------- timing pulses ----------------

  dco_pkg::dco_arm_type arm_ff;      // arming state
  dco_pkg::dco_arm_type nxt_arm;
  logic                 arm_d_ff;    // arm level last cycle
  logic [31:0]          sec_cnt_ff;  // frames within a second
  logic [3:0]           tens_cnt_ff; // seconds within ten
  logic                 p1_ff;       // one-second pulse
  logic                 p10_ff;      // ten-second pulse

  // control is expected to arm inside the coincidence window only;
  // an arm outside it starts the pulses at the wrong second
  wire arm_rise  = I_ARM & ~arm_d_ff;
  // received frame clock: one tick per frame handed on
  wire frame_tick = capture;
  wire start     = (arm_ff == dco_pkg::ARM_WAIT) &
                   frame_tick & fif[0].mfi;
  wire sec_wrap  = (sec_cnt_ff ==
                    32'(FRAMES_PER_SEC * `DCO_PULSE_SHORT_S - 1));
  wire tens_wrap = (tens_cnt_ff ==
                    4'(`DCO_PULSE_LONG_S / `DCO_PULSE_SHORT_S - 1));
  wire running   = (arm_ff == dco_pkg::ARM_RUN);

  // arming sequence, a fresh arm restarts the count
  always_comb
  begin
    nxt_arm = arm_ff;
    unique case (arm_ff)
      dco_pkg::ARM_IDLE:
        if (arm_rise)
          nxt_arm = dco_pkg::ARM_WAIT;
      dco_pkg::ARM_WAIT:
        if (start)
          nxt_arm = dco_pkg::ARM_RUN;
      dco_pkg::ARM_RUN:
        if (arm_rise)
          nxt_arm = dco_pkg::ARM_WAIT;
      default:
        nxt_arm = dco_pkg::ARM_IDLE;
    endcase
  end

  // state and arm edge
  always_ff @(posedge I_CLK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      arm_ff   <= dco_pkg::ARM_IDLE;
      arm_d_ff <= 1'b0;
    end
    else
    begin
      arm_ff   <= nxt_arm;
      arm_d_ff <= I_ARM;
    end
  end

  // frame and second counters, both pulses on the starting frame
  always_ff @(posedge I_CLK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      sec_cnt_ff  <= 32'h0000_0000;
      tens_cnt_ff <= 4'h0;
      p1_ff       <= 1'b0;
      p10_ff      <= 1'b0;
    end
    else
    begin
      p1_ff  <= start | (running & frame_tick & sec_wrap);
      p10_ff <= start |
                (running & frame_tick & sec_wrap & tens_wrap);
      if (start)
      begin
        sec_cnt_ff  <= 32'h0000_0000;
        tens_cnt_ff <= 4'h0;
      end
      else if (running & frame_tick)
      begin
        sec_cnt_ff <= sec_wrap ? 32'h0000_0000
                               : sec_cnt_ff + 32'h0000_0001;
        if (sec_wrap)
          tens_cnt_ff <= tens_wrap ? 4'h0 : tens_cnt_ff + 4'h1;
      end
    end
  end

  assign O_PULSE_1S  = p1_ff;
  assign O_PULSE_10S = p10_ff;
  assign O_COUNT_RUN = (arm_ff == dco_pkg::ARM_RUN);

  // ---------------- link domain ----------------
  // I_LINK_CLK is the PLL output locked to the reference,
  // twice the forwarded clock rate

  logic         ref_s1_ff;   // reference sync, first stage
  logic         ref_s2_ff;   // reference sync, second stage
  logic         ref_d_ff;    // for edge detect
  logic         req_s1_ff;   // request sync, first stage
  logic         req_s2_ff;   // request sync, second stage
  logic [1:0]   word_ff;     // word of frame on the bus
  logic [383:0] cur_ff;      // frames being sent
  logic [95:0]  out_ff;      // words on the three paths
  logic         ddr_ff;      // forwarded clock
  logic         inv_ff;      // invalid flag on the bus

  // the reference passes two stages before the edge detector
  always_ff @(posedge I_LINK_CLK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      // held high: a reference already high is not taken as a rise
      ref_s1_ff <= 1'b1;
      ref_s2_ff <= 1'b1;
      ref_d_ff  <= 1'b1;
      req_s1_ff <= 1'b0;
      req_s2_ff <= 1'b0;
    end
    else
    begin
      ref_s1_ff <= I_REF_CLK;
      ref_s2_ff <= ref_s1_ff;
      ref_d_ff  <= ref_s2_ff;
      req_s1_ff <= req_ff;
      req_s2_ff <= req_s1_ff;
    end
  end

  wire       ref_rise = ref_s2_ff & ~ref_d_ff;
  // a fresh frame is waiting when request and ack differ
  wire       fresh    = (req_s2_ff != ack_ff);
  // on a reference rise the opening word goes out
  wire [1:0] sel      = ref_rise ? 2'h0 : word_ff + 2'h1;
  wire [383:0] src    = (ref_rise & fresh) ? hold_ff : cur_ff;

  // word selection for all paths
  wire [95:0] nxt_out;
  for (g = 0; g < 3; g++)
  begin : g_sel
    assign nxt_out[g*32 +: 32] = src[g*128 + sel*32 +: 32];
  end

  // frame load and handshake; a missed frame repeats, flagged
  always_ff @(posedge I_LINK_CLK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      ack_ff <= 1'b0;
      cur_ff <= '0;
      inv_ff <= 1'b1;
    end
    else if (ref_rise)
    begin
      cur_ff <= src;
      inv_ff <= fresh ? hold_inv_ff : 1'b1;
      if (fresh)
        ack_ff <= req_s2_ff;
    end
  end

  // one word per link cycle, forwarded clock edge with each word
  always_ff @(posedge I_LINK_CLK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      word_ff <= 2'h0;
      out_ff  <= '0;
      ddr_ff  <= 1'b0;
    end
    else
    begin
      word_ff <= sel;
      out_ff  <= nxt_out;
      ddr_ff  <= ref_rise ? 1'b1 : ~ddr_ff;
    end
  end

  assign O_PATH0_DATA   = out_ff[31:0];
  assign O_PATH1_DATA   = out_ff[63:32];
  assign O_PATH2_DATA   = out_ff[95:64];
  assign O_DDR_CLK      = ddr_ff;
  assign O_DATA_INVALID = inv_ff;

endmodule // dco_correlator_out

`default_nettype wire

/* dco_params.svh */
`ifndef DCO_PARAMS_SVH
`define DCO_PARAMS_SVH

// channel and word geometry
`define DCO_CHANNELS        3
`define DCO_WORD_W          32
`define DCO_WORDS_PER_FRAME 4
`define DCO_FRAME_W         128
`define DCO_ALL_FRAMES_W    384
`define DCO_FCNT_W          16
`define DCO_SAMPLE_W        8

// converter codes that flag input over range
`define DCO_ADC_CODE_MAX    8'hff
`define DCO_ADC_CODE_MIN    8'h00

// timing pulses, periods in seconds
`define DCO_PULSE_SHORT_S   1
`define DCO_PULSE_LONG_S    10
// received frame rate per second, default for the counter parameter
`define DCO_FRAME_RATE_HZ   64000000
`define DCO_SEC_CNT_W       32
`define DCO_TENS_CNT_W      4

`endif

/* dco_pkg.sv */
package dco_pkg;

  // pulse counter arming, one-hot
  typedef enum logic [2:0]
  {
    ARM_IDLE  = 3'b001,
    ARM_WAIT  = 3'b010,
    ARM_RUN   = 3'b100
  } dco_arm_type;

  typedef logic [31:0]  dco_word_type;
  typedef logic [127:0] dco_frame_type;

endpackage

/* dco_frame_if.sv */
`timescale 1ns/1ps
`default_nettype none

// one assembled frame handed from an assembler to the core
interface dco_frame_if;
  dco_pkg::dco_frame_type frame;  // word0 in the low bits
  logic                   valid;  // frame complete, held
  logic                   ready;  // core takes it this cycle
  logic [15:0]            fcnt;   // received frame counter
  logic                   mfi;    // metaframe index bit
  logic                   ovr;    // over range seen in frame

  modport asm_side (output frame, valid, fcnt, mfi, ovr, input ready);
  modport core_side (input frame, valid, fcnt, mfi, ovr, output ready);
endinterface

`default_nettype wire

/* dco_frame_asm.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dco_params.svh"

// gathers four words of one channel into a held frame
module dco_frame_asm
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // received words of one channel
  input  wire logic [31:0] i_word,
  input  wire logic        i_valid,
  input  wire logic        i_sof,
  input  wire logic [15:0] i_fcnt,
  input  wire logic        i_mfi,
  // three-bit samples carried
  input  wire logic        i_mode3,
  // frame towards the core
  dco_frame_if.asm_side    fr
);

  logic [1:0]   idx_ff;   // next word slot
  logic [127:0] buf_ff;   // frame words
  logic         ovr_ff;   // over range in this frame
  logic         full_ff;  // frame complete, waiting
  logic [15:0]  fcnt_ff;  // counter of first word
  logic         mfi_ff;   // index bit of first word

  // per-sample over range test
  logic [3:0] byte_hit;
  genvar b;
  for (b = 0; b < 4; b++)
  begin : g_byte
    assign byte_hit[b] =
      (i_word[b*8 +: 8] == `DCO_ADC_CODE_MAX) ||
      (i_word[b*8 +: 8] == `DCO_ADC_CODE_MIN);
  end

  // over range ignored for three-bit samples
  wire       word_ovr = (|byte_hit) & ~i_mode3;
  // words arriving while a frame waits are dropped
  wire       take     = i_valid & ~full_ff;
  wire [1:0] pos      = i_sof ? 2'h0 : idx_ff;
  wire       last     = take & (pos == 2'h3);

  // word slots and frame tags
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      idx_ff  <= 2'h0;
      buf_ff  <= '0;
      ovr_ff  <= 1'b0;
      fcnt_ff <= 16'h0000;
      mfi_ff  <= 1'b0;
    end
    else if (take)
    begin
      idx_ff                <= pos + 2'h1;
      buf_ff[pos*32 +: 32]  <= i_word;
      ovr_ff                <= word_ovr | (ovr_ff & (pos != 2'h0));
      if (pos == 2'h0)
      begin
        fcnt_ff <= i_fcnt;
        mfi_ff  <= i_mfi;
      end
    end
  end

  // held until the core takes it
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      full_ff <= 1'b0;
    else if (last)
      full_ff <= 1'b1;
    else if (fr.ready)
      full_ff <= 1'b0;
  end

  assign fr.frame = buf_ff;
  assign fr.valid = full_ff;
  assign fr.fcnt  = fcnt_ff;
  assign fr.mfi   = mfi_ff;
  assign fr.ovr   = ovr_ff;

endmodule // dco_frame_asm

`default_nettype wire

/* dco_correlator_out_assertions.sv */
`timescale 1ns/1ps
`default_nettype none

// watches pacing, pulses and the invalid flag at the top ports
module dco_correlator_out_assertions
#(
  parameter int unsigned FRAMES_PER_SEC = 8
)
(
  // clocks and reset
  input  wire logic       I_CLK,
  input  wire logic       I_RESET_N,
  input  wire logic       I_LINK_CLK,
  // watched inputs
  input  wire logic       I_REF_CLK,
  input  wire logic [2:0] I_CH_SYNC,
  input  wire logic       I_ARM,
  // watched outputs
  input  wire logic       O_DDR_CLK,
  input  wire logic       O_DATA_INVALID,
  input  wire logic       O_PULSE_1S,
  input  wire logic       O_PULSE_10S,
  input  wire logic       O_COUNT_RUN
);
  logic started_ff;  // forwarded clock has begun
  logic nxt_started;

  // idle zeros right after reset are not judged as missed toggles
  assign nxt_started = started_ff | O_DDR_CLK;

  // remembers the first high of the forwarded clock
  always_ff @(posedge I_LINK_CLK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
      started_ff <= 1'b0;
    else
      started_ff <= nxt_started;
  end

  // sync lost on some channel for a while
  sequence s_sync_lost;
    !(&I_CH_SYNC) [*8];
  endsequence

  // counters just began
  sequence s_run_start;
    $rose(O_COUNT_RUN);
  endsequence

  ddr_toggle_a:
    assert property (@(posedge I_LINK_CLK) disable iff (!I_RESET_N)
      started_ff |=> $changed(O_DDR_CLK))
    else $error("forwarded clock missed a toggle");
  ref_align_a:
    assert property (@(posedge I_LINK_CLK) disable iff (!I_RESET_N)
      $rose(I_REF_CLK) |-> ##3 $rose(O_DDR_CLK))
    else $error("no frame start after reference rise");
  inv_nosync_a:
    assert property (@(posedge I_LINK_CLK) disable iff (!I_RESET_N)
      s_sync_lost |-> ##[0:10] O_DATA_INVALID)
    else $error("invalid flag low while sync lost");
  pulse_gap_a:
    assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      O_PULSE_1S |=> !O_PULSE_1S [*8])
    else $error("second pulses too close");
  long_short_a:
    assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      O_PULSE_10S |-> O_PULSE_1S)
    else $error("ten second pulse without one second pulse");
  start_both_a:
    assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      s_run_start |-> O_PULSE_1S && O_PULSE_10S)
    else $error("counter start without both pulses");
  run_hold_a:
    assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      O_COUNT_RUN && !I_ARM |=> O_COUNT_RUN)
    else $error("counters stopped without a new arm");
  pulse_run_a:
    assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      O_PULSE_1S |-> O_COUNT_RUN)
    else $error("pulse while counters idle");
endmodule // dco_correlator_out_assertions

`default_nettype wire

/* dco_corr_card_model.sv */
`timescale 1ns/1ps
`default_nettype none

// correlator card side: a reference that never stops
module dco_corr_card_model
(
  // word clock of the link
  input  wire logic i_link_clk,
  // reference towards the block
  output var  logic o_ref_clk
);
  logic [1:0] div_ff = 2'h0;  // four words per reference period

  // divided from the link clock so the phase stays fixed
  always_ff @(posedge i_link_clk)
  begin
    div_ff <= div_ff + 2'h1;
  end

  assign o_ref_clk = div_ff[1];
endmodule // dco_corr_card_model

`default_nettype wire

/* tb_dco_correlator_out.sv */
`timescale 1ns/1ps
`default_nettype none

// sends received frames, checks words, flag and pulses
module tb_dco_correlator_out;
  localparam int unsigned FPS = 8;  // short second keeps run small
  logic        I_CLK, I_RESET_N, I_LINK_CLK, I_REF_CLK;
  logic [95:0] I_CH_DATA;
  logic [47:0] I_CH_FCNT;
  logic [2:0]  I_CH_VALID, I_CH_SOF, I_CH_MFI, I_CH_SYNC;
  logic        I_SAMPLE_3BIT, I_ARM;
  logic [31:0] O_PATH0_DATA, O_PATH1_DATA, O_PATH2_DATA;
  logic        O_DDR_CLK, O_DATA_INVALID;
  logic        O_PULSE_1S, O_PULSE_10S, O_COUNT_RUN;
  int          fail_count, checks;
  logic [31:0] n1 = '0;         // one-second pulses seen
  logic [31:0] n10 = '0;        // ten-second pulses seen
  logic [7:0]  nb;              // base byte, fresh per frame
  logic [31:0] exp_w [3][4];    // expected words per channel

  always #5 I_CLK = ~I_CLK;
  always #32 I_LINK_CLK = ~I_LINK_CLK;

  dco_corr_card_model u_card (.i_link_clk(I_LINK_CLK), .o_ref_clk(I_REF_CLK));

  dco_correlator_out #(.FRAMES_PER_SEC(FPS)) u_dut
  (
    .I_CLK(I_CLK), .I_RESET_N(I_RESET_N), .I_LINK_CLK(I_LINK_CLK),
    .I_REF_CLK(I_REF_CLK), .I_CH_DATA(I_CH_DATA),
    .I_CH_VALID(I_CH_VALID), .I_CH_SOF(I_CH_SOF), .I_CH_FCNT(I_CH_FCNT),
    .I_CH_MFI(I_CH_MFI), .I_CH_SYNC(I_CH_SYNC),
    .I_SAMPLE_3BIT(I_SAMPLE_3BIT), .I_ARM(I_ARM),
    .O_PATH0_DATA(O_PATH0_DATA), .O_PATH1_DATA(O_PATH1_DATA),
    .O_PATH2_DATA(O_PATH2_DATA), .O_DDR_CLK(O_DDR_CLK),
    .O_DATA_INVALID(O_DATA_INVALID), .O_PULSE_1S(O_PULSE_1S),
    .O_PULSE_10S(O_PULSE_10S), .O_COUNT_RUN(O_COUNT_RUN)
  );

  // pulse tally, one count per high cycle
  always @(posedge I_CLK)
  begin
    if (O_PULSE_1S === 1'b1)
      n1 <= n1 + 32'h0000_0001;
    if (O_PULSE_10S === 1'b1)
      n10 <= n10 + 32'h0000_0001;
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic cmp32(input string nm, input logic [31:0] e, g);
    checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cmp1(input string nm, input logic e, g);
    checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("ERROR %s expected %b seen %b", nm, e, g);
    end
  endtask

  // one frame on all channels; bytes avoid the extreme codes except for oc and where nb nears 8'hff
  task automatic send(input logic mis, mfi, odd, input logic [7:0] oc);
    nb = nb + 8'h0c;
    for (int c = 0; c < 3; c++)
      for (int k = 0; k < 4; k++)
        exp_w[c][k] = {4{nb + 8'(c * 4 + k)}};
    if (odd)
      exp_w[1][2][7:0] = oc;
    for (int k = 0; k < 4; k++)
    begin
      @(negedge I_CLK);
      I_CH_VALID = 3'h7;
      I_CH_SOF = (k == 0) ? 3'h7 : 3'h0;
      I_CH_DATA = {exp_w[2][k], exp_w[1][k], exp_w[0][k]};
      I_CH_FCNT = {3{8'h00, nb}} ^ (mis ? 48'h0000_0001_0000 : '0);
      I_CH_MFI = {3{mfi}};
    end
    @(negedge I_CLK);
    I_CH_VALID = 3'h0;
    I_CH_SOF = 3'h0;
  endtask

  // finds the frame's first delivery, then reads four words
  task automatic chk(input logic inv);
    int n;
    n = 0;
    while (O_PATH0_DATA !== exp_w[0][0] && n < 60)
    begin
      @(negedge I_LINK_CLK);
      n++;
    end
    if (n == 60)
    begin
      fail_count++;
      $display("ERROR frame expected %h seen none", exp_w[0][0]);
      wrap_up();
    end
    else
    begin
      cmp1("ddr_clk", 1'b1, O_DDR_CLK);
      cmp1("invalid", inv, O_DATA_INVALID);
      for (int k = 0; k < 4; k++)
      begin
        cmp32("path0", exp_w[0][k], O_PATH0_DATA);
        cmp32("path1", exp_w[1][k], O_PATH1_DATA);
        cmp32("path2", exp_w[2][k], O_PATH2_DATA);
        @(negedge I_LINK_CLK);
      end
    end
  endtask

  // main sequence
  initial
  begin
    I_CLK = 1'b0;
    I_LINK_CLK = 1'b0;
    I_RESET_N = 1'b0;
    I_CH_DATA = '0;
    I_CH_VALID = 3'h0;
    I_CH_SOF = 3'h0;
    I_CH_FCNT = '0;
    I_CH_MFI = 3'h0;
    I_CH_SYNC = 3'h7;
    I_SAMPLE_3BIT = 1'b0;
    I_ARM = 1'b0;
    nb = 8'h04;
    fail_count = 0;
    checks = 0;
    repeat (16) @(negedge I_CLK);
    I_RESET_N = 1'b1;
    cmp1("invalid", 1'b1, O_DATA_INVALID);
    cmp1("run", 1'b0, O_COUNT_RUN);
    $display("test reset done");
    send(1'b0, 1'b0, 1'b0, 8'h00);
    chk(1'b0);
    send(1'b1, 1'b0, 1'b0, 8'h00);
    chk(1'b1);
    // both extreme codes, in 8-bit then 3-bit mode
    for (int m = 0; m < 4; m++)
    begin
      I_SAMPLE_3BIT = m[1];
      send(1'b0, 1'b0, 1'b1, m[0] ? 8'hff : 8'h00);
      chk(~m[1]);
    end
    I_SAMPLE_3BIT = 1'b0;
    I_CH_SYNC = 3'h3;
    send(1'b0, 1'b0, 1'b0, 8'h00);
    chk(1'b1);
    I_CH_SYNC = 3'h7;
    send(1'b0, 1'b0, 1'b0, 8'h00);
    chk(1'b0);
    $display("test invalid flag done");
    @(negedge I_CLK);
    I_ARM = 1'b1;
    @(negedge I_CLK);
    I_ARM = 1'b0;
    send(1'b0, 1'b0, 1'b0, 8'h00);
    repeat (40) @(negedge I_CLK);
    cmp1("run", 1'b0, O_COUNT_RUN);
    send(1'b0, 1'b1, 1'b0, 8'h00);
    repeat (40) @(negedge I_CLK);
    cmp1("run", 1'b1, O_COUNT_RUN);
    cmp32("count_1s", 32'h0000_0001, n1);
    cmp32("count_10s", 32'h0000_0001, n10);
    // a second spans exactly FPS received frames
    for (int i = 0; i < FPS; i++)
    begin
      if (i == FPS - 1)
        cmp32("count_1s", 32'h0000_0001, n1);
      send(1'b0, 1'b0, 1'b0, 8'h00);
      repeat (40) @(negedge I_CLK);
    end
    cmp32("count_1s", 32'h0000_0002, n1);
    cmp32("count_10s", 32'h0000_0001, n10);
    // nine more seconds: the tenth brings the long pulse again
    for (int i = 0; i < 9 * FPS; i++)
    begin
      if (i == 9 * FPS - 1)
      begin
        cmp32("count_1s", 32'h0000_000a, n1);
        cmp32("count_10s", 32'h0000_0001, n10);
      end
      send(1'b0, 1'b0, 1'b0, 8'h00);
      repeat (40) @(negedge I_CLK);
    end
    cmp32("count_1s", 32'h0000_000b, n1);
    cmp32("count_10s", 32'h0000_0002, n10);
    $display("test pulses done");
    wrap_up();
  end
endmodule // tb_dco_correlator_out

bind dco_correlator_out dco_correlator_out_assertions
  #(.FRAMES_PER_SEC(FRAMES_PER_SEC)) u_chk
  (
    .I_CLK(I_CLK), .I_RESET_N(I_RESET_N), .I_LINK_CLK(I_LINK_CLK),
    .I_REF_CLK(I_REF_CLK), .I_CH_SYNC(I_CH_SYNC), .I_ARM(I_ARM),
    .O_DDR_CLK(O_DDR_CLK), .O_DATA_INVALID(O_DATA_INVALID),
    .O_PULSE_1S(O_PULSE_1S), .O_PULSE_10S(O_PULSE_10S),
    .O_COUNT_RUN(O_COUNT_RUN)
  );

`default_nettype wire
